// ---- logic/led_cfg_pkg.sv ----
// Constants, field layouts and types for the node configuration and status indicator block.
package led_cfg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 500_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int FAST_HALF_NS = 62_500_000;
  localparam int FAST_HALF_TICKS = FAST_HALF_NS / TICK_NS;
  localparam int SLOW_HALF_MS = 500;
  localparam int SLOW_HALF_TICKS = SLOW_HALF_MS * 1_000_000 / TICK_NS;
  localparam int STEP_MS = 250;
  localparam int STEP_TICKS = STEP_MS * 1_000_000 / TICK_NS;
  localparam int TEST_END_MS = 2000;
  localparam int TEST_STEPS = TEST_END_MS / STEP_MS;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  localparam int ADDR_BITS = 6;
  localparam int RATE_LSB = 6;
  localparam logic [6:0] MAX_PD_WORDS = 7'h40;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_NODE_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFS_LED_STATE = 8'h14;
  localparam logic [31:0] NODE_CTRL_RST = 32'h0040_0000;
  localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // NODE_CTRL fields.
  localparam int F_STATE_LSB = 0;
  localparam int F_POLLED_LSB = 3;
  localparam int F_STROBE_LSB = 5;
  localparam int F_MINOR = 7;
  localparam int F_CRITICAL = 8;
  localparam int F_WARNING = 9;
  localparam int F_PD_LSB = 16;

  // CONFIG fields.
  localparam int F_CFG_RATE_LSB = 8;
  localparam int F_CFG_RATE_BAD = 10;
  localparam int F_CFG_PD_BAD = 11;
  localparam int F_CFG_TEST_DONE = 12;

  // Interrupt bits.
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_RATE_BAD = 1;
  localparam int IRQ_BUS_OFF = 2;
  localparam int IRQ_TEST_DONE = 3;

  // Indicator positions.
  localparam int LED_MODNET = 0;
  localparam int LED_POLLED = 1;
  localparam int LED_STROBE = 2;
  localparam int LED_FAULT = 3;

  typedef enum logic [2:0] {
    NODE_OFFLINE = 3'b000,
    NODE_DUP_CHECK = 3'b001,
    NODE_DUP_FAIL = 3'b010,
    NODE_ONLINE = 3'b011,
    NODE_BUS_OFF = 3'b100
  } node_state_e;

  typedef enum logic [1:0] {
    CONN_IDLE = 2'b00,
    CONN_CONFIGURING = 2'b01,
    CONN_ESTABLISHED = 2'b10,
    CONN_TIMEOUT = 2'b11
  } conn_e;

  typedef enum logic [1:0] {
    RATE_125K = 2'b00,
    RATE_250K = 2'b01,
    RATE_500K = 2'b10,
    RATE_INVALID = 2'b11
  } rate_e;

endpackage

// ---- logic/node_status_leds.sv ----
// Switch decode, status indicator patterns and AXI4-Lite register file of a fieldbus node.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Node address is switches 0..5 as binary, switch 0 least significant.
// - Every address from 0 to 63 is accepted.
// - Switches 6,7: 00=125k, 6 only=250k, 7 only=500k, both=invalid.
// - Invalid rate is a minor fault: polled indicator flashes red, 1 s period.
// - Up to 64 process data words are supported.
// - Four two-colour indicators: module/network, polled, bit-strobe, bus fault.
// - Module/network dark when offline or during duplicate address check.
// - Module/network flashes green, 1 s, when online without established connection.
// - Module/network steady green with an established connection.
// - Module/network flashes red, 1 s, on correctable fault or connection timeout.
// - Module/network steady red on bus-off or failed duplicate check or critical.
// - Polled flashes green 125 ms during duplicate check, dark when offline.
// - Polled flashes green, 1 s, while configuring or configuration incomplete.
// - Polled steady green once the polled connection is established.
// - Polled flashes red, 1 s, on polled timeout or correctable fault.
// - Polled steady red on unrecoverable fault, bus-off or failed duplicate check.
// - After reset each indicator shows green then red 250 ms each; all off at 2 s.
module node_status_leds #(
  parameter int TICK_CYCLES = led_cfg_pkg::TICK_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] SWITCH_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [7:0] ARADDR_I,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic [5:0] NODE_ADDRESS_O,
  output logic [1:0] RATE_SEL_O,
  output logic RATE_INVALID_O,
  output logic [6:0] PD_WORDS_O,
  output logic [3:0] LED_GREEN_O,
  output logic [3:0] LED_RED_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // Switch synchroniser and decode
  // ----------------------------------------------------------------
  logic [7:0] sw_meta_ff;
  logic [7:0] sw_sync_ff;
  logic [7:0] sw_prev_ff;
  logic [5:0] node_address_ff;
  logic [1:0] rate_sel_ff;
  logic rate_invalid_ff;

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      sw_meta_ff <= 8'h00;
      sw_sync_ff <= 8'h00;
      sw_prev_ff <= 8'h00;
    end else begin
      sw_meta_ff <= SWITCH_I;
      sw_sync_ff <= sw_meta_ff;
      sw_prev_ff <= sw_sync_ff;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      node_address_ff <= 6'h00;
      rate_sel_ff <= 2'h0;
      rate_invalid_ff <= 1'b0;
    end else begin
      node_address_ff <= sw_sync_ff[led_cfg_pkg::ADDR_BITS-1:0];
      rate_sel_ff <= sw_sync_ff[led_cfg_pkg::RATE_LSB +: 2];
      rate_invalid_ff <= (sw_sync_ff[led_cfg_pkg::RATE_LSB +: 2] == led_cfg_pkg::RATE_INVALID);
    end
  end

  // ----------------------------------------------------------------
  // Timebase, flash phases and power-up sequence
  // ----------------------------------------------------------------
  logic [14:0] tick_cnt_ff;
  logic tick;
  logic [9:0] fast_cnt_ff;
  logic [9:0] slow_cnt_ff;
  logic fast_ph_ff;
  logic slow_ph_ff;
  logic [9:0] step_cnt_ff;
  logic [3:0] step_ff;
  logic test_done;

  assign tick = (tick_cnt_ff == 15'(TICK_CYCLES - 1));
  assign test_done = (step_ff == 4'(led_cfg_pkg::TEST_STEPS));

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I || tick) begin
      tick_cnt_ff <= 15'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 15'h0001;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      fast_cnt_ff <= 10'h000;
      slow_cnt_ff <= 10'h000;
      fast_ph_ff <= 1'b0;
      slow_ph_ff <= 1'b0;
    end else if (tick) begin
      if (fast_cnt_ff == 10'(led_cfg_pkg::FAST_HALF_TICKS - 1)) begin
        fast_cnt_ff <= 10'h000;
        fast_ph_ff <= !fast_ph_ff;
      end else begin
        fast_cnt_ff <= fast_cnt_ff + 10'h001;
      end
      if (slow_cnt_ff == 10'(led_cfg_pkg::SLOW_HALF_TICKS - 1)) begin
        slow_cnt_ff <= 10'h000;
        slow_ph_ff <= !slow_ph_ff;
      end else begin
        slow_cnt_ff <= slow_cnt_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      step_cnt_ff <= 10'h000;
      step_ff <= 4'h0;
    end else if (tick && !test_done) begin
      if (step_cnt_ff == 10'(led_cfg_pkg::STEP_TICKS - 1)) begin
        step_cnt_ff <= 10'h000;
        step_ff <= step_ff + 4'h1;
      end else begin
        step_cnt_ff <= step_cnt_ff + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic [31:0] node_ctrl_ff;
  logic [3:0] irq_enable_ff;
  logic [3:0] irq_status_ff;
  led_cfg_pkg::node_state_e node_state;
  led_cfg_pkg::conn_e polled_conn;
  led_cfg_pkg::conn_e strobe_conn;
  logic minor_fault;
  logic critical_fault;
  logic bus_warning;
  logic [6:0] pd_req;
  logic pd_invalid;
  logic [6:0] pd_words_ff;
  logic bus_off_prev_ff;
  logic rate_prev_ff;
  logic test_prev_ff;
  logic [3:0] events;

  assign node_state = led_cfg_pkg::node_state_e'(node_ctrl_ff[led_cfg_pkg::F_STATE_LSB +: 3]);
  assign polled_conn = led_cfg_pkg::conn_e'(node_ctrl_ff[led_cfg_pkg::F_POLLED_LSB +: 2]);
  assign strobe_conn = led_cfg_pkg::conn_e'(node_ctrl_ff[led_cfg_pkg::F_STROBE_LSB +: 2]);
  assign minor_fault = node_ctrl_ff[led_cfg_pkg::F_MINOR];
  assign critical_fault = node_ctrl_ff[led_cfg_pkg::F_CRITICAL];
  assign bus_warning = node_ctrl_ff[led_cfg_pkg::F_WARNING];
  assign pd_req = node_ctrl_ff[led_cfg_pkg::F_PD_LSB +: 7];
  assign pd_invalid = (pd_req > led_cfg_pkg::MAX_PD_WORDS);

  // A count beyond the maximum is clamped so the data path never overruns.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      pd_words_ff <= led_cfg_pkg::MAX_PD_WORDS;
    end else begin
      pd_words_ff <= pd_invalid ? led_cfg_pkg::MAX_PD_WORDS : pd_req;
    end
  end

  // ----------------------------------------------------------------
  // Indicator patterns
  // ----------------------------------------------------------------
  logic [3:0] nxt_green;
  logic [3:0] nxt_red;
  logic [3:0] green_ff;
  logic [3:0] red_ff;
  logic hard_red;
  logic dup_check;
  logic dark;

  assign hard_red = critical_fault || (node_state == led_cfg_pkg::NODE_BUS_OFF)
      || (node_state == led_cfg_pkg::NODE_DUP_FAIL);
  assign dup_check = (node_state == led_cfg_pkg::NODE_DUP_CHECK);
  assign dark = (node_state == led_cfg_pkg::NODE_OFFLINE) || dup_check;

  always_comb begin
    nxt_green = 4'h0;
    nxt_red = 4'h0;
    if (!test_done) begin
      nxt_green[step_ff[2:1]] = !step_ff[0];
      nxt_red[step_ff[2:1]] = step_ff[0];
    end else begin
      // Module and network status.
      if (hard_red) begin
        nxt_red[led_cfg_pkg::LED_MODNET] = 1'b1;
      end else if (minor_fault || polled_conn == led_cfg_pkg::CONN_TIMEOUT
          || strobe_conn == led_cfg_pkg::CONN_TIMEOUT) begin
        nxt_red[led_cfg_pkg::LED_MODNET] = slow_ph_ff;
      end else if (dark) begin
        nxt_green[led_cfg_pkg::LED_MODNET] = 1'b0;
      end else if (polled_conn == led_cfg_pkg::CONN_ESTABLISHED
          || strobe_conn == led_cfg_pkg::CONN_ESTABLISHED) begin
        nxt_green[led_cfg_pkg::LED_MODNET] = 1'b1;
      end else begin
        nxt_green[led_cfg_pkg::LED_MODNET] = slow_ph_ff;
      end
      // Polled connection.
      if (hard_red) begin
        nxt_red[led_cfg_pkg::LED_POLLED] = 1'b1;
      end else if (rate_invalid_ff || minor_fault
          || polled_conn == led_cfg_pkg::CONN_TIMEOUT) begin
        nxt_red[led_cfg_pkg::LED_POLLED] = slow_ph_ff;
      end else if (dup_check) begin
        nxt_green[led_cfg_pkg::LED_POLLED] = fast_ph_ff;
      end else if (node_state == led_cfg_pkg::NODE_OFFLINE) begin
        nxt_green[led_cfg_pkg::LED_POLLED] = 1'b0;
      end else if (polled_conn == led_cfg_pkg::CONN_ESTABLISHED) begin
        nxt_green[led_cfg_pkg::LED_POLLED] = 1'b1;
      end else begin
        nxt_green[led_cfg_pkg::LED_POLLED] = slow_ph_ff;
      end
      // Bit-strobe connection follows the same pattern on its own connection, with pd_invalid in place of rate_invalid_ff.
      if (hard_red) begin
        nxt_red[led_cfg_pkg::LED_STROBE] = 1'b1;
      end else if (pd_invalid || minor_fault
          || strobe_conn == led_cfg_pkg::CONN_TIMEOUT) begin
        nxt_red[led_cfg_pkg::LED_STROBE] = slow_ph_ff;
      end else if (dup_check) begin
        nxt_green[led_cfg_pkg::LED_STROBE] = fast_ph_ff;
      end else if (node_state == led_cfg_pkg::NODE_OFFLINE) begin
        nxt_green[led_cfg_pkg::LED_STROBE] = 1'b0;
      end else if (strobe_conn == led_cfg_pkg::CONN_ESTABLISHED) begin
        nxt_green[led_cfg_pkg::LED_STROBE] = 1'b1;
      end else begin
        nxt_green[led_cfg_pkg::LED_STROBE] = slow_ph_ff;
      end
      // Bus fault shows the physical error state only.
      if (node_state == led_cfg_pkg::NODE_BUS_OFF) begin
        nxt_red[led_cfg_pkg::LED_FAULT] = 1'b1;
      end else if (bus_warning && dup_check) begin
        nxt_red[led_cfg_pkg::LED_FAULT] = fast_ph_ff;
      end else if (bus_warning) begin
        nxt_red[led_cfg_pkg::LED_FAULT] = slow_ph_ff;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      green_ff <= 4'h0;
      red_ff <= 4'h0;
    end else begin
      green_ff <= nxt_green;
      red_ff <= nxt_red;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      bus_off_prev_ff <= 1'b0;
      rate_prev_ff <= 1'b0;
      test_prev_ff <= 1'b0;
    end else begin
      bus_off_prev_ff <= (node_state == led_cfg_pkg::NODE_BUS_OFF);
      rate_prev_ff <= rate_invalid_ff;
      test_prev_ff <= test_done;
    end
  end

  always_comb begin
    events = 4'h0;
    events[led_cfg_pkg::IRQ_SWITCH] = (sw_sync_ff != sw_prev_ff);
    events[led_cfg_pkg::IRQ_RATE_BAD] = rate_invalid_ff && !rate_prev_ff;
    events[led_cfg_pkg::IRQ_BUS_OFF] = (node_state == led_cfg_pkg::NODE_BUS_OFF)
        && !bus_off_prev_ff;
    events[led_cfg_pkg::IRQ_TEST_DONE] = test_done && !test_prev_ff;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic [31:0] wmask;
  logic [3:0] irq_clear;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  assign AWREADY_O = !aw_held_ff && !bvalid_ff;
  assign WREADY_O = !w_held_ff && !bvalid_ff;
  assign ARREADY_O = !rvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign irq_clear = (do_write && awaddr_ff == led_cfg_pkg::OFS_IRQ_CLEAR)
      ? (wdata_ff[3:0] & wmask[3:0]) : 4'h0;

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {AWADDR_I[7:2], 2'b00};
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_held_ff <= 1'b1;
        wdata_ff <= WDATA_I;
        wstrb_ff <= WSTRB_I;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= led_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      case (awaddr_ff)
        led_cfg_pkg::OFS_NODE_CTRL,
        led_cfg_pkg::OFS_IRQ_CLEAR,
        led_cfg_pkg::OFS_IRQ_ENABLE: bresp_ff <= led_cfg_pkg::RESP_OKAY;
        default: bresp_ff <= led_cfg_pkg::RESP_SLVERR;
      endcase
    end else if (BREADY_I) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      node_ctrl_ff <= led_cfg_pkg::NODE_CTRL_RST;
      irq_enable_ff <= led_cfg_pkg::IRQ_ENABLE_RST;
    end else if (do_write) begin
      if (awaddr_ff == led_cfg_pkg::OFS_NODE_CTRL) begin
        node_ctrl_ff <= (node_ctrl_ff & ~wmask) | (wdata_ff & wmask);
      end
      if (awaddr_ff == led_cfg_pkg::OFS_IRQ_ENABLE) begin
        irq_enable_ff <= (irq_enable_ff & ~wmask[3:0]) | (wdata_ff[3:0] & wmask[3:0]);
      end
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      irq_status_ff <= 4'h0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | events;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = led_cfg_pkg::RESP_OKAY;
    case ({ARADDR_I[7:2], 2'b00})
      led_cfg_pkg::OFS_NODE_CTRL: nxt_rdata = node_ctrl_ff;
      led_cfg_pkg::OFS_CONFIG: begin
        nxt_rdata[5:0] = node_address_ff;
        nxt_rdata[led_cfg_pkg::F_CFG_RATE_LSB +: 2] = rate_sel_ff;
        nxt_rdata[led_cfg_pkg::F_CFG_RATE_BAD] = rate_invalid_ff;
        nxt_rdata[led_cfg_pkg::F_CFG_PD_BAD] = pd_invalid;
        nxt_rdata[led_cfg_pkg::F_CFG_TEST_DONE] = test_done;
      end
      led_cfg_pkg::OFS_IRQ_STATUS: nxt_rdata[3:0] = irq_status_ff;
      led_cfg_pkg::OFS_IRQ_CLEAR: nxt_rdata = 32'h0000_0000;
      led_cfg_pkg::OFS_IRQ_ENABLE: nxt_rdata[3:0] = irq_enable_ff;
      led_cfg_pkg::OFS_LED_STATE: nxt_rdata[7:0] = {red_ff, green_ff};
      default: nxt_rresp = led_cfg_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= led_cfg_pkg::RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign BVALID_O = bvalid_ff;
  assign BRESP_O = bresp_ff;
  assign RVALID_O = rvalid_ff;
  assign RDATA_O = rdata_ff;
  assign RRESP_O = rresp_ff;
  assign NODE_ADDRESS_O = node_address_ff;
  assign RATE_SEL_O = rate_sel_ff;
  assign RATE_INVALID_O = rate_invalid_ff;
  assign PD_WORDS_O = pd_words_ff;
  assign LED_GREEN_O = green_ff;
  assign LED_RED_O = red_ff;
  assign IRQ_O = |(irq_status_ff & irq_enable_ff);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  a_addr_binary: assert property ($past(RSTN_I) && $past(RSTN_I, 2)
      |=> NODE_ADDRESS_O == $past(SWITCH_I[5:0], 3))
    else $error("node address does not follow the low switches");
  a_rate_decode: assert property ($past(RSTN_I) && $past(RSTN_I, 2)
      |=> RATE_INVALID_O == (&$past(SWITCH_I[7:6], 3)))
    else $error("invalid rate flag does not follow the rate switches");
  a_rate_flash: assert property (test_done && rate_invalid_ff && !hard_red |=>
      !LED_GREEN_O[1] && LED_RED_O[1] == $past(slow_ph_ff))
    else $error("polled indicator not flashing red on invalid rate");
  a_modnet_dark: assert property (test_done && dark && !hard_red && !minor_fault
      && polled_conn != led_cfg_pkg::CONN_TIMEOUT && strobe_conn != led_cfg_pkg::CONN_TIMEOUT
      |=> !LED_GREEN_O[0] && !LED_RED_O[0])
    else $error("module indicator lit while offline");
  a_modnet_steady: assert property (test_done && $stable(node_ctrl_ff) && hard_red
      |=> LED_RED_O[0] && !LED_GREEN_O[0])
    else $error("module indicator not steady red on critical failure");
  a_dup_fast: assert property (test_done && dup_check && !hard_red && !rate_invalid_ff
      && !minor_fault && polled_conn != led_cfg_pkg::CONN_TIMEOUT
      |=> LED_GREEN_O[1] == $past(fast_ph_ff))
    else $error("polled indicator not on fast flash during duplicate check");
  a_test_single: assert property (!test_done |=> $onehot(LED_GREEN_O | LED_RED_O))
    else $error("power-up sequence lights other than one indicator colour");
  a_slow_period: assert property (tick
      && slow_cnt_ff == 10'(led_cfg_pkg::SLOW_HALF_TICKS - 1)
      |=> slow_ph_ff != $past(slow_ph_ff) && slow_cnt_ff == 10'h000)
    else $error("slow flash phase did not toggle at its half period");
  a_pd_clamp: assert property (PD_WORDS_O <= led_cfg_pkg::MAX_PD_WORDS)
    else $error("process data word count above maximum");

endmodule // node_status_leds

`default_nettype wire

// ---- test/node_status_leds_tb.sv ----
// Self-checking bench for the node switch decode and status indicators.
`timescale 1ns/100ps
`default_nettype none
module node_status_leds_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sw = 8'h00;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, r_data;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, rate_bad, irq;
  logic [1:0] b_resp, r_resp, rate;
  logic [5:0] addr;
  logic [6:0] pd, words;
  logic [3:0] grn, red;
  int n_errors = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  scanner_model scanner_model_i (.pd_words_o(words));
  node_status_leds #(.TICK_CYCLES(2)) node_status_leds_i (
    .CLOCK_I(clk), .RSTN_I(rstn), .SWITCH_I(sw), .AWVALID_I(awv), .AWREADY_O(aw_rdy),
    .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(w_rdy), .WDATA_I(wd), .WSTRB_I(4'hF),
    .BVALID_O(b_v), .BREADY_I(brdy), .BRESP_O(b_resp), .ARVALID_I(arv),
    .ARREADY_O(ar_rdy), .ARADDR_I(ara), .RVALID_O(r_v), .RREADY_I(rrdy), .RDATA_O(r_data),
    .RRESP_O(r_resp), .NODE_ADDRESS_O(addr), .RATE_SEL_O(rate), .RATE_INVALID_O(rate_bad),
    .PD_WORDS_O(pd), .LED_GREEN_O(grn), .LED_RED_O(red), .IRQ_O(irq));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    tb = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awv && aw_rdy;
      tw = wv && w_rdy;
      tb = b_v;
      rs = b_resp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    brdy <= 1'b0;
    if (!tb) n_errors++;
    if (!tb) test_done();
    chk("write response", er, rs);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rs;
    tr = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge clk);
      ta = arv && ar_rdy;
      tr = r_v;
      d = r_data;
      rs = r_resp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rrdy <= 1'b0;
    if (!tr) n_errors++;
    if (!tr) test_done();
    chk("read data", ed, d);
    chk("read response", er, rs);
  endtask
  // Mode seen on one indicator bit: 0 dark, 1 steady, 2 slow flash, 3 fast flash.
  task automatic led_mode(input int b, input int m);
    logic [7:0] v;
    logic last;
    logic unk;
    int hi, ed;
    hi = 0;
    ed = 0;
    unk = 1'b0;
    repeat (8) @(posedge clk);
    for (int n = 0; n < 2200; n++) begin
      @(negedge clk);
      v = {red, grn};
      if ($isunknown(v[b])) unk = 1'b1;
      if (v[b] === 1'b1) hi++;
      if (n > 0 && v[b] !== last) ed++;
      last = v[b];
    end
    chk($sformatf("indicator bit %0d", b), m,
        unk ? 32'hXXXX_XXXX : hi == 0 ? 0 : hi == 2200 ? 1 : ed > 4 ? 3 : 2);
  endtask
  function automatic logic [31:0] ctrl(input logic [2:0] s, input logic [1:0] p);
    return {9'h000, words, 11'h000, p, s};
  endfunction
  task automatic t_powerup();
    repeat (500) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      chk("power-up", i < 8 ? 32'h1 << (4 * (i % 2) + i / 2) : 32'h0, {red, grn});
      repeat (1000) @(posedge clk);
    end
    rdchk(led_cfg_pkg::OFS_NODE_CTRL, led_cfg_pkg::NODE_CTRL_RST, led_cfg_pkg::RESP_OKAY);
    rdchk(led_cfg_pkg::OFS_IRQ_ENABLE, 32'h0, led_cfg_pkg::RESP_OKAY);
    $display("power-up test done");
  endtask
  task automatic t_switches();
    logic [7:0] sv [4] = '{8'h00, 8'h6A, 8'hBF, 8'hC5};
    logic [1:0] rt [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sw <= sv[i];
      repeat (6) @(posedge clk);
      chk("address", sv[i][5:0], addr);
      chk("rate", rt[i], rate);
      chk("rate invalid", i == 3, rate_bad);
    end
    $display("switch test done");
  endtask
  task automatic t_leds();
    wr(8'h00, ctrl(led_cfg_pkg::NODE_ONLINE, led_cfg_pkg::CONN_ESTABLISHED), 2'h0);
    led_mode(5, 2);
    led_mode(0, 1);
    @(posedge clk);
    sw <= 8'h2A;
    led_mode(1, 1);
    wr(8'h00, ctrl(led_cfg_pkg::NODE_ONLINE, led_cfg_pkg::CONN_CONFIGURING), 2'h0);
    led_mode(0, 2);
    led_mode(1, 2);
    wr(8'h00, ctrl(led_cfg_pkg::NODE_ONLINE, led_cfg_pkg::CONN_TIMEOUT), 2'h0);
    led_mode(4, 2);
    led_mode(5, 2);
    wr(8'h00, ctrl(led_cfg_pkg::NODE_DUP_CHECK, led_cfg_pkg::CONN_IDLE), 2'h0);
    led_mode(0, 0);
    led_mode(4, 0);
    led_mode(1, 3);
    wr(8'h00, ctrl(led_cfg_pkg::NODE_BUS_OFF, led_cfg_pkg::CONN_IDLE), 2'h0);
    led_mode(4, 1);
    led_mode(5, 1);
    wr(8'h00, ctrl(led_cfg_pkg::NODE_OFFLINE, led_cfg_pkg::CONN_IDLE), 2'h0);
    led_mode(1, 0);
    $display("indicator test done");
  endtask
  task automatic t_regs();
    rdchk(8'h40, 32'h0, led_cfg_pkg::RESP_SLVERR);
    wr(led_cfg_pkg::OFS_CONFIG, 32'hFFFF_FFFF, led_cfg_pkg::RESP_SLVERR);
    rdchk(led_cfg_pkg::OFS_CONFIG, 32'h0000_102A, 2'h0);
    chk("word count", words, pd);
    rdchk(led_cfg_pkg::OFS_IRQ_STATUS, 32'hF, 2'h0);
    wr(led_cfg_pkg::OFS_IRQ_ENABLE, 32'h1, 2'h0);
    chk("irq enabled", 1'b1, irq);
    wr(led_cfg_pkg::OFS_IRQ_CLEAR, 32'hF, 2'h0);
    chk("irq cleared", 1'b0, irq);
    sw <= 8'h2B;
    repeat (8) @(posedge clk);
    chk("irq raised", 1'b1, irq);
    wr(led_cfg_pkg::OFS_IRQ_ENABLE, 32'h0, 2'h0);
    chk("irq masked", 1'b0, irq);
    wr(led_cfg_pkg::OFS_NODE_CTRL, 32'h007F_0003, 2'h0);
    @(negedge clk);
    chk("word clamp", led_cfg_pkg::MAX_PD_WORDS, pd);
    $display("register test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_switches();
    t_leds();
    t_regs();
    test_done();
  end
endmodule // node_status_leds_tb
`default_nettype wire

// ---- test/scanner_model.sv ----
// Model of the bus master scanner that sets the process data word count.
`timescale 1ns/100ps
`default_nettype none
module scanner_model #(
  parameter logic [6:0] WORDS = 7'h40
) (
  output logic [6:0] pd_words_o
);
  assign pd_words_o = WORDS;
endmodule // scanner_model
`default_nettype wire
